// ---- bmce_pkg.sv ----
package bmce_pkg;
  // storage sizes
  localparam int AUX_COUNT = 8;
  localparam int STACK_DEPTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 16;

  // opcodes (high byte of the first word; accumulator call is the whole word, conditional call its top six bits)
  localparam logic [7:0] OPC_PGM_MOVE = 8'hA5;
  localparam logic [15:0] OPC_ACC_CALL = 16'hBE30;
  localparam logic [7:0] OPC_IMM_CALL = 8'h7A;
  localparam logic [5:0] OPC_COND_CALL = 6'h3A;

  // first-word field positions
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 8;
  localparam int CC_LSB = 10;
  localparam int IND_BIT = 7;
  localparam int ARU_MSB = 6;
  localparam int ARU_LSB = 4;
  localparam int NXT_BIT = 3;
  localparam int NAR_MSB = 2;
  localparam int NAR_LSB = 0;
  localparam int DMA_MSB = 6;
  localparam int DMA_LSB = 0;

  // auxiliary register update codes
  localparam logic [2:0] ARU_HOLD = 3'h0;
  localparam logic [2:0] ARU_DEC = 3'h1;
  localparam logic [2:0] ARU_INC = 3'h2;
  localparam logic [2:0] ARU_BR_DEC = 3'h4;
  localparam logic [2:0] ARU_IDX_DEC = 3'h5;
  localparam logic [2:0] ARU_IDX_INC = 3'h6;
  localparam logic [2:0] ARU_BR_INC = 3'h7;

  // cycle figures
  localparam logic [17:0] CYC_MOVE_BASE = 18'h00003;
  localparam logic [17:0] CYC_MOVE_SLOW = 18'h00004;
  localparam logic [17:0] CYC_CALL = 18'h00004;
  localparam logic [17:0] CYC_SKIP = 18'h00002;
  localparam logic [17:0] CYC_RPT_EXTRA = 18'h00002;
  localparam logic [17:0] CYC_RPT_SHARED = 18'h00004;
  localparam logic [17:0] CYC_AT_START = 18'h00002;

  // program counter steps and reset values
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [16:0] WORDS_ONE = 17'h00001;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_CALL} bmce_state_t;
endpackage

// ---- bmce_stream_if.sv ----
`timescale 1ns/10ps
// one word stream with valid/ready handshake
interface bmce_stream_if #(parameter int WIDTH = 16);
  logic valid; // word on data is offered
  logic ready; // receiver takes it this cycle
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- bmce_fifo.sv ----
`timescale 1ns/10ps
module bmce_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  bmce_stream_if.snk wr_s,
  bmce_stream_if.src rd_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH]; // word storage
  logic [AW-1:0] wptr_reg; // next slot to fill
  logic [AW-1:0] rptr_reg; // oldest word
  logic [AW:0] cnt_reg; // words held
  logic wr_fire;
  logic rd_fire;

  ////////////////////////////////////////////////////////////////////
  // full stalls writer, empty stalls reader
  assign wr_s.ready = cnt_reg != FULL_CNT;
  assign rd_s.valid = cnt_reg != '0;
  assign rd_s.data = mem_reg[rptr_reg];
  assign wr_fire = wr_s.valid && wr_s.ready;
  assign rd_fire = rd_s.valid && rd_s.ready;

  // storage needs no reset
  always_ff @(posedge clk) begin
    if (wr_fire) begin
      mem_reg[wptr_reg] <= wr_s.data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (wr_fire) begin
        wptr_reg <= (wptr_reg == LAST_PTR) ? '0 : wptr_reg + 1'b1;
      end
      if (rd_fire) begin
        rptr_reg <= (rptr_reg == LAST_PTR) ? '0 : rptr_reg + 1'b1;
      end
    end
  end

  // occupancy; push with pop holds it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (wr_fire && !rd_fire) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (rd_fire && !wr_fire) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// ---- bmce_exec.sv ----
`timescale 1ns/10ps
// Overview of operation
// - move copies program word to data word
// - second word gives first source address
// - direct offset seven bits, next register 0-7
// - destination direct or via auxiliary register
// - repeated move transfers counter plus one words
// - source address held in counter, steps one
// - save return, count down, then restore
// - indirect move updates register and pointer
// - direct destination stays fixed when repeated
// - interrupts held off during repeated move
// - repeated transfers then take one cycle each
// - any mix of on-chip and external memory
// - single move three cycles, shared block four
// - repeated move n+2, shared operands 2n
// - operands and code sharing block: 2n+2
// - external destination: four plus wait states
// - accumulator call pushes return, jumps low half
// - accumulator call four cycles, drops prefetch
// - immediate call pushes pc+2, optional register update
// - immediate call four cycles, flushes two words
// - conditional call acts as call or skips
module bmce_exec (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  input wire logic [15:0] INSTR_WORD0,
  input wire logic [15:0] INSTR_WORD1,
  input wire logic REPEAT_ACTIVE,
  input wire logic [15:0] REPEAT_COUNT,
  input wire logic [31:0] ACCUMULATOR,
  input wire logic COND_TRUE,
  input wire logic [8:0] DATA_PAGE,
  input wire logic DST_EXTERNAL,
  input wire logic DST_CODE_SHARED,
  input wire logic SRC_DST_SHARED,
  output logic PMEM_RD,
  output logic [15:0] PMEM_ADDR,
  input wire logic [15:0] PMEM_RDATA,
  input wire logic PMEM_RDY,
  output logic DMEM_WR,
  output logic [15:0] DMEM_ADDR,
  output logic [15:0] DMEM_WDATA,
  input wire logic DMEM_RDY,
  output logic [15:0] PC,
  output logic [15:0] MICRO_STACK,
  output logic [15:0] STACK_TOP,
  output logic [2:0] AUX_POINTER,
  output logic [15:0] AUX_CURRENT,
  output logic [15:0] REPEAT_COUNTER,
  output logic INT_INHIBIT,
  output logic PREFETCH_DISCARD,
  output logic BUSY,
  output logic DONE
);

  ////////////////////////////////////////////////////////////////////
  // helper functions

  // bit reversal for reverse-carry stepping
  function automatic logic [15:0] bit_rev(input logic [15:0] a);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = a[15-i];
    end
    return r;
  endfunction

  // one register step, move and call
  function automatic logic [15:0] ar_step(
    input logic [15:0] a,
    input logic [15:0] idx,
    input logic [2:0] aru
  );
    logic [15:0] r;
    r = a;
    case (aru)
      bmce_pkg::ARU_DEC: r = a - bmce_pkg::PC_STEP_ONE;
      bmce_pkg::ARU_INC: r = a + bmce_pkg::PC_STEP_ONE;
      bmce_pkg::ARU_IDX_DEC: r = a - idx;
      bmce_pkg::ARU_IDX_INC: r = a + idx;
      bmce_pkg::ARU_BR_INC: r = bit_rev(bit_rev(a) + bit_rev(idx));
      bmce_pkg::ARU_BR_DEC: r = bit_rev(bit_rev(a) - bit_rev(idx));
      default: r = a; // hold, and the unused code
    endcase
    return r;
  endfunction

  // least cycles of a move
  function automatic logic [17:0] move_cycles(
    input logic rep,
    input logic [15:0] n,
    input logic dst_ext,
    input logic dst_code,
    input logic src_dst
  );
    logic [17:0] nn;
    nn = {2'b00, n};
    if (!rep) begin
      // shared block or external bus: one more
      return (dst_ext || dst_code) ? bmce_pkg::CYC_MOVE_SLOW
                                   : bmce_pkg::CYC_MOVE_BASE;
    end
    if (src_dst && dst_code) begin
      return (nn << 1) + bmce_pkg::CYC_RPT_EXTRA;
    end
    if (src_dst) begin
      return nn << 1;
    end
    if (dst_ext) begin
      return (nn << 1) + bmce_pkg::CYC_RPT_EXTRA;
    end
    if (dst_code) begin
      return nn + bmce_pkg::CYC_RPT_SHARED;
    end
    return nn + bmce_pkg::CYC_RPT_EXTRA;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  bmce_pkg::bmce_state_t state_reg; // sequencer
  logic [15:0] pc_reg; // program counter
  logic [15:0] micro_stack_reg; // return address held across a move
  logic [15:0] stack_reg [bmce_pkg::STACK_DEPTH]; // entry 0 is top
  logic [15:0] ar_reg [bmce_pkg::AUX_COUNT]; // auxiliary registers
  logic [2:0] arp_reg; // auxiliary pointer
  logic [15:0] rpt_reg; // repeat counter
  logic first_rd_reg; // first source word not yet read
  logic [16:0] wr_left_reg; // destination writes still owed
  logic [17:0] cyc_reg; // cycles spent in the instruction
  logic [17:0] min_reg; // least cycles the instruction takes
  logic [15:0] word0_reg; // first word of the running move
  logic [15:0] dir_addr_reg; // direct destination address
  logic inhibit_reg; // interrupts held off
  logic discard_reg; // prefetched words dropped
  logic done_reg; // instruction finished

  ////////////////////////////////////////////////////////////////////
  // decode

  logic [7:0] opc;
  logic is_move; // program-to-data move
  logic is_acall; // accumulator call
  logic is_call; // immediate call
  logic is_cc; // conditional call
  logic accept; // instruction taken this cycle
  logic take_call; // call discontinuity taken
  logic [15:0] ctl_word; // first word steering register updates

  assign opc = INSTR_WORD0[bmce_pkg::OPC_MSB:bmce_pkg::OPC_LSB];
  assign is_move = opc == bmce_pkg::OPC_PGM_MOVE;
  assign is_acall = INSTR_WORD0 == bmce_pkg::OPC_ACC_CALL;
  assign is_call = opc == bmce_pkg::OPC_IMM_CALL;
  assign is_cc = INSTR_WORD0[bmce_pkg::OPC_MSB:bmce_pkg::CC_LSB]
                 == bmce_pkg::OPC_COND_CALL;
  assign INSTR_READY = state_reg == bmce_pkg::ST_IDLE;
  assign accept = INSTR_VALID && INSTR_READY;
  // a condition that fails leaves only the skip
  assign take_call = accept && (is_call || (is_cc && COND_TRUE));
  assign ctl_word = INSTR_READY ? INSTR_WORD0 : word0_reg;

  ////////////////////////////////////////////////////////////////////
  // source side: program reads fill the buffer

  bmce_stream_if #(.WIDTH(bmce_pkg::WORD_W)) fill_s ();
  bmce_stream_if #(.WIDTH(bmce_pkg::WORD_W)) drain_s ();

  logic rd_req; // a source word is still wanted
  logic rd_fire; // source word arrives
  logic first_fire; // the first source word arrives
  logic wr_fire; // destination word written
  logic last_wr; // all writes done by the end of this cycle
  logic move_end; // move finishes this cycle
  logic call_end; // call or skip finishes this cycle

  // first read goes out in the accept cycle;
  // later reads run while the buffer has room
  assign rd_req = (accept && is_move)
                  || (state_reg == bmce_pkg::ST_MOVE
                      && (first_rd_reg || rpt_reg != '0));
  assign PMEM_RD = rd_req && fill_s.ready;
  assign PMEM_ADDR = INSTR_READY ? INSTR_WORD1 : pc_reg;
  assign fill_s.valid = PMEM_RD && PMEM_RDY; // wait states via ready
  assign fill_s.data = PMEM_RDATA;
  assign rd_fire = fill_s.valid;
  assign first_fire = rd_fire && (INSTR_READY || first_rd_reg);

  // buffer decouples the two sides' waits
  bmce_fifo #(
    .WIDTH(bmce_pkg::WORD_W),
    .DEPTH(bmce_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst_n(RESETN),
    .wr_s(fill_s),
    .rd_s(drain_s)
  );

  ////////////////////////////////////////////////////////////////////
  // destination side: buffer drains into data memory

  assign DMEM_WR = state_reg == bmce_pkg::ST_MOVE && drain_s.valid;
  assign drain_s.ready = state_reg == bmce_pkg::ST_MOVE && DMEM_RDY;
  assign DMEM_WDATA = drain_s.data;
  // indirect follows the pointer, direct never moves
  assign DMEM_ADDR = word0_reg[bmce_pkg::IND_BIT] ? ar_reg[arp_reg]
                                                  : dir_addr_reg;
  assign wr_fire = DMEM_WR && DMEM_RDY;
  assign last_wr = wr_left_reg == '0 || (wr_left_reg == bmce_pkg::WORDS_ONE && wr_fire);
  assign move_end = state_reg == bmce_pkg::ST_MOVE && last_wr && cyc_reg >= min_reg;
  assign call_end = state_reg == bmce_pkg::ST_CALL && cyc_reg >= min_reg;

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_reg <= bmce_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        bmce_pkg::ST_IDLE: begin
          if (accept && is_move) begin
            state_reg <= bmce_pkg::ST_MOVE;
          end else if (accept && (is_acall || is_call || is_cc)) begin
            state_reg <= bmce_pkg::ST_CALL;
          end
        end
        bmce_pkg::ST_MOVE: begin
          if (move_end) begin
            state_reg <= bmce_pkg::ST_IDLE;
          end
        end
        bmce_pkg::ST_CALL: begin
          if (call_end) begin
            state_reg <= bmce_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // cycle budget: the slower of this and the memories wins
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cyc_reg <= '0;
      min_reg <= '0;
    end else if (accept) begin
      cyc_reg <= bmce_pkg::CYC_AT_START;
      if (is_move) begin
        min_reg <= move_cycles(REPEAT_ACTIVE, REPEAT_COUNT, DST_EXTERNAL,
                               DST_CODE_SHARED, SRC_DST_SHARED);
      end else if (is_acall || take_call) begin
        min_reg <= bmce_pkg::CYC_CALL;
      end else begin
        min_reg <= bmce_pkg::CYC_SKIP;
      end
    end else if (!INSTR_READY) begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // program counter

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pc_reg <= bmce_pkg::PC_RESET;
    end else if (accept) begin
      if (is_move) begin
        // counter holds the source address
        pc_reg <= first_fire ? INSTR_WORD1 + bmce_pkg::PC_STEP_ONE
                             : INSTR_WORD1;
      end else if (is_acall) begin
        pc_reg <= ACCUMULATOR[15:0];
      end else if (take_call) begin
        pc_reg <= INSTR_WORD1;
      end else if (is_cc) begin
        pc_reg <= pc_reg + bmce_pkg::PC_STEP_TWO;
      end else begin
        pc_reg <= pc_reg + bmce_pkg::PC_STEP_ONE;
      end
    end else if (move_end) begin
      pc_reg <= micro_stack_reg;
    end else if (rd_fire) begin
      pc_reg <= pc_reg + bmce_pkg::PC_STEP_ONE;
    end
  end

  // return past both move words
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      micro_stack_reg <= bmce_pkg::PC_RESET;
    end else if (accept && is_move) begin
      micro_stack_reg <= pc_reg + bmce_pkg::PC_STEP_TWO;
    end
  end

  // push-down stack, bottom entry lost
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      for (int i = 0; i < bmce_pkg::STACK_DEPTH; i++) begin
        stack_reg[i] <= bmce_pkg::PC_RESET;
      end
    end else if (accept && (is_acall || take_call)) begin
      for (int i = bmce_pkg::STACK_DEPTH - 1; i > 0; i--) begin
        stack_reg[i] <= stack_reg[i-1];
      end
      stack_reg[0] <= is_acall ? pc_reg + bmce_pkg::PC_STEP_ONE
                               : pc_reg + bmce_pkg::PC_STEP_TWO;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // repeat counting

  // repetitions left after the first word
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rpt_reg <= '0;
      first_rd_reg <= 1'b0;
    end else if (accept && is_move) begin
      rpt_reg <= REPEAT_ACTIVE ? REPEAT_COUNT : '0;
      first_rd_reg <= !first_fire;
    end else if (rd_fire && state_reg == bmce_pkg::ST_MOVE) begin
      if (first_rd_reg) begin
        first_rd_reg <= 1'b0;
      end else begin
        rpt_reg <= rpt_reg - bmce_pkg::PC_STEP_ONE;
      end
    end
  end

  // writes owed; move ends when the last lands
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wr_left_reg <= '0;
    end else if (accept && is_move) begin
      wr_left_reg <= {1'b0, (REPEAT_ACTIVE ? REPEAT_COUNT : 16'h0000)}
                     + bmce_pkg::WORDS_ONE;
    end else if (wr_fire) begin
      wr_left_reg <= wr_left_reg - bmce_pkg::WORDS_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // destination addressing

  // direct address is built once and kept for every repetition
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      word0_reg <= '0;
      dir_addr_reg <= '0;
    end else if (accept && is_move) begin
      word0_reg <= INSTR_WORD0;
      dir_addr_reg <= {DATA_PAGE,
                       INSTR_WORD0[bmce_pkg::DMA_MSB:bmce_pkg::DMA_LSB]};
    end
  end

  // register and pointer step after each indirect write,
  // or at once for an indirect call; index comes from register 0
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      for (int i = 0; i < bmce_pkg::AUX_COUNT; i++) begin
        ar_reg[i] <= '0;
      end
      arp_reg <= '0;
    end else if ((wr_fire && word0_reg[bmce_pkg::IND_BIT])
                 || (take_call && INSTR_WORD0[bmce_pkg::IND_BIT])) begin
      ar_reg[arp_reg] <= ar_step(ar_reg[arp_reg], ar_reg[0],
                                 ctl_word[bmce_pkg::ARU_MSB:bmce_pkg::ARU_LSB]);
      if (ctl_word[bmce_pkg::NXT_BIT]) begin
        arp_reg <= ctl_word[bmce_pkg::NAR_MSB:bmce_pkg::NAR_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status pulses and levels

  // held from accept to the end of a repeated move only
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      inhibit_reg <= 1'b0;
    end else if (accept && is_move && REPEAT_ACTIVE) begin
      inhibit_reg <= 1'b1;
    end else if (move_end) begin
      inhibit_reg <= 1'b0;
    end
  end

  // pulse: fetch stage drops its two words
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      discard_reg <= 1'b0;
    end else begin
      discard_reg <= accept && (is_acall || take_call);
    end
  end

  // unknown words just step the counter and finish at once
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= move_end || call_end
                  || (accept && !is_move && !is_acall && !is_call && !is_cc);
    end
  end

  assign PC = pc_reg;
  assign MICRO_STACK = micro_stack_reg;
  assign STACK_TOP = stack_reg[0];
  assign AUX_POINTER = arp_reg;
  assign AUX_CURRENT = ar_reg[arp_reg];
  assign REPEAT_COUNTER = rpt_reg;
  assign INT_INHIBIT = inhibit_reg;
  assign PREFETCH_DISCARD = discard_reg;
  assign BUSY = !INSTR_READY;
  assign DONE = done_reg;
endmodule

// ---- bmce_mem_model.sv ----
`timescale 1ns/10ps
// program and data memory stand-in
// mode 0 no waits, 1 random, 2 writes stalled
module bmce_mem_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [15:0] rdata,
  output logic rd_rdy,
  output logic wr_rdy
);
  logic [15:0] last_reg = 16'h0000; // last word handed out
  initial begin
    rd_rdy = 1'b0;
    wr_rdy = 1'b0;
  end
  // waits change off the sampling edge
  always @(negedge clk) begin
    rd_rdy <= (mode == 2'h1) ? 1'($urandom % 2) : 1'b1;
    wr_rdy <= (mode == 2'h0) || ((mode == 2'h1) && 1'($urandom % 2));
  end
  always @(posedge clk) begin
    if (rd && rd_rdy) begin
      last_reg <= rdata;
    end
  end
  // word only in the completing cycle, else stale inverse
  assign rdata = (rd && rd_rdy) ? (addr ^ 16'hC3A5) : ~last_reg;
endmodule

// ---- bmce_exec_asserts.sv ----
`timescale 1ns/10ps
// port-level checks of the execution block
module bmce_exec_asserts (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic INSTR_VALID,
  input wire logic INSTR_READY,
  input wire logic [15:0] INSTR_WORD0,
  input wire logic [15:0] INSTR_WORD1,
  input wire logic REPEAT_ACTIVE,
  input wire logic [31:0] ACCUMULATOR,
  input wire logic COND_TRUE,
  input wire logic [8:0] DATA_PAGE,
  input wire logic PMEM_RD,
  input wire logic [15:0] PMEM_ADDR,
  input wire logic PMEM_RDY,
  input wire logic DMEM_WR,
  input wire logic [15:0] DMEM_ADDR,
  input wire logic [15:0] DMEM_WDATA,
  input wire logic DMEM_RDY,
  input wire logic [15:0] PC,
  input wire logic [15:0] STACK_TOP,
  input wire logic PREFETCH_DISCARD,
  input wire logic INT_INHIBIT,
  input wire logic BUSY,
  input wire logic DONE
);
  ////////////////////////////////////////
  wire take = INSTR_VALID && INSTR_READY; // instruction accepted
  wire mov_go = take && (INSTR_WORD0[15:8] == bmce_pkg::OPC_PGM_MOVE);
  wire acc_go = take && (INSTR_WORD0 == bmce_pkg::OPC_ACC_CALL);
  wire imm_go = take && (INSTR_WORD0[15:8] == bmce_pkg::OPC_IMM_CALL);
  wire cc_go = take && (INSTR_WORD0[15:10] == bmce_pkg::OPC_COND_CALL);
  logic dir_reg; // move in flight writes a direct place
  logic [15:0] daddr_reg; // that place
  // direct destination at accept
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      dir_reg <= 1'b0;
      daddr_reg <= 16'h0000;
    end else if (take) begin
      dir_reg <= (INSTR_WORD0[15:8] == bmce_pkg::OPC_PGM_MOVE) && !INSTR_WORD0[7];
      daddr_reg <= {DATA_PAGE, INSTR_WORD0[6:0]};
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  move_read_a: assert property (mov_go |-> PMEM_RD && PMEM_ADDR == INSTR_WORD1)
    else $error("source not fetched");
  src_step_a: assert property (PMEM_RD && PMEM_RDY ##1 PMEM_RD && BUSY
    |-> PMEM_ADDR == $past(PMEM_ADDR) + 16'h0001) else $error("source did not step");
  dst_fixed_a: assert property (BUSY && DMEM_WR && dir_reg |-> DMEM_ADDR == daddr_reg)
    else $error("direct destination moved");
  rpt_inhibit_a: assert property (mov_go && REPEAT_ACTIVE |=> INT_INHIBIT && BUSY)
    else $error("interrupts open");
  acc_call_a: assert property (acc_go |=> PC == $past(ACCUMULATOR[15:0])
    && STACK_TOP == $past(PC) + 16'h0001) else $error("acc call target wrong");
  acc_len_a: assert property (acc_go |=> PREFETCH_DISCARD && BUSY ##1 BUSY[*2] ##1 DONE)
    else $error("acc call length wrong");
  imm_call_a: assert property (imm_go || cc_go && COND_TRUE |=> PC == $past(INSTR_WORD1)
    && STACK_TOP == $past(PC) + 16'h0002) else $error("immediate call wrong");
  cc_skip_a: assert property (cc_go && !COND_TRUE |=> !PREFETCH_DISCARD ##1 DONE)
    else $error("false cond call wrong");
  wr_hold_a: assert property (DMEM_WR && !DMEM_RDY |=> DMEM_WR && $stable(DMEM_WDATA)
    && $stable(DMEM_ADDR)) else $error("write not held");
endmodule
bind bmce_exec bmce_exec_asserts u_bmce_exec_asserts (.CLOCK, .RESETN, .INSTR_VALID,
  .INSTR_READY, .INSTR_WORD0, .INSTR_WORD1, .REPEAT_ACTIVE, .ACCUMULATOR, .COND_TRUE,
  .DATA_PAGE, .PMEM_RD, .PMEM_ADDR, .PMEM_RDY, .DMEM_WR, .DMEM_ADDR, .DMEM_WDATA, .DMEM_RDY,
  .PC, .STACK_TOP, .PREFETCH_DISCARD, .INT_INHIBIT, .BUSY, .DONE);

// ---- block_move_call_exec_tb.sv ----
`timescale 1ns/10ps
module block_move_call_exec_tb;
  logic CLOCK = 1'b0, RESETN = 1'b0, INSTR_VALID = 1'b0, REPEAT_ACTIVE = 1'b0, COND_TRUE = 1'b0;
  logic DST_EXTERNAL = 1'b0, DST_CODE_SHARED = 1'b0, SRC_DST_SHARED = 1'b0;
  logic [15:0] INSTR_WORD0 = 16'h0000, INSTR_WORD1 = 16'h0000, REPEAT_COUNT = 16'h0000;
  logic [31:0] ACCUMULATOR = 32'h00000000;
  logic [8:0] DATA_PAGE = 9'h000;
  logic [1:0] mode = 2'h0; // memory behaviour
  logic PMEM_RDY, DMEM_RDY, PMEM_RD, DMEM_WR, INSTR_READY, INT_INHIBIT, PREFETCH_DISCARD, BUSY;
  logic DONE, ind, nxt; // ind/nxt: destination mode of the move under test
  logic [15:0] PMEM_RDATA, PMEM_ADDR, DMEM_ADDR, DMEM_WDATA, PC, MICRO_STACK, STACK_TOP;
  logic [15:0] AUX_CURRENT, REPEAT_COUNTER, exp_pc, pma, dir_addr, exp_ar [8];
  logic [2:0] AUX_POINTER, ptr, nar;
  logic [2:0] fl_tab [5] = '{3'b000, 3'b010, 3'b100, 3'b001, 3'b011}; // operand placements
  int error_cnt = 0, total_checks = 0, wcnt, rcnt, cyc;

  always #25 CLOCK = ~CLOCK;

  bmce_exec u_bmce_exec (.CLOCK, .RESETN, .INSTR_VALID, .INSTR_READY, .INSTR_WORD0, .INSTR_WORD1,
    .REPEAT_ACTIVE, .REPEAT_COUNT, .ACCUMULATOR, .COND_TRUE, .DATA_PAGE, .DST_EXTERNAL,
    .DST_CODE_SHARED, .SRC_DST_SHARED, .PMEM_RD, .PMEM_ADDR, .PMEM_RDATA, .PMEM_RDY, .DMEM_WR,
    .DMEM_ADDR, .DMEM_WDATA, .DMEM_RDY, .PC, .MICRO_STACK, .STACK_TOP, .AUX_POINTER, .AUX_CURRENT,
    .REPEAT_COUNTER, .INT_INHIBIT, .PREFETCH_DISCARD, .BUSY, .DONE);
  bmce_mem_model u_bmce_mem_model (.clk(CLOCK), .mode, .rd(PMEM_RD), .addr(PMEM_ADDR),
    .rdata(PMEM_RDATA), .rd_rdy(PMEM_RDY), .wr_rdy(DMEM_RDY));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // move length with no waits
  function automatic int exp_min(input logic rep, input int n, input logic [2:0] fl);
    if (!rep) return (fl[2] || fl[1]) ? 4 : 3;
    case (fl)
      3'b010: return n + 4;
      3'b100: return 2 * n + 2;
      3'b001: return 2 * n;
      3'b011: return 2 * n + 2;
      default: return n + 2;
    endcase
  endfunction

  // each write: right word, right place
  always @(posedge CLOCK) begin
    if (PMEM_RD && PMEM_RDY) rcnt++;
    if (DMEM_WR && DMEM_RDY) begin
      chk(DMEM_WDATA, (pma + 16'(wcnt)) ^ 16'hC3A5);
      chk(DMEM_ADDR, ind ? exp_ar[ptr] : dir_addr);
      if (ind) begin
        exp_ar[ptr] = exp_ar[ptr] + 16'h0001;
        if (nxt) ptr = nar;
      end
      wcnt++;
    end
  end

  // offer one word pair, count cycles to done; a hang is left to the guard
  task automatic run(input logic [15:0] w0, input logic [15:0] w1);
    @(negedge CLOCK);
    INSTR_WORD0 = w0;
    INSTR_WORD1 = w1;
    INSTR_VALID = 1'b1;
    @(negedge CLOCK);
    INSTR_VALID = 1'b0;
    cyc = 1;
    while (DONE !== 1'b1) begin
      @(negedge CLOCK);
      cyc++;
    end
  endtask

  task automatic move(input logic rep, input logic [15:0] n, input logic [2:0] fl);
    logic [15:0] w0;
    ind = 1'($urandom % 2);
    nxt = 1'($urandom % 2);
    nar = 3'($urandom);
    pma = 16'($urandom);
    DATA_PAGE = 9'($urandom);
    {DST_EXTERNAL, DST_CODE_SHARED, SRC_DST_SHARED} = fl;
    REPEAT_ACTIVE = rep;
    REPEAT_COUNT = n;
    w0 = {bmce_pkg::OPC_PGM_MOVE, ind, ind ? {bmce_pkg::ARU_INC, nxt, nar} : 7'($urandom)};
    dir_addr = {DATA_PAGE, w0[6:0]};
    wcnt = 0;
    rcnt = 0;
    run(w0, pma);
    chk(wcnt, rep ? n + 1 : 1);
    chk(rcnt, rep ? n + 1 : 1);
    if (mode == 2'h0) chk(cyc, exp_min(rep, n, fl));
    chk(PC, exp_pc + 16'h0002);
    chk(MICRO_STACK, exp_pc + 16'h0002);
    chk(REPEAT_COUNTER, 16'h0000);
    chk(AUX_CURRENT, exp_ar[ptr]);
    chk(AUX_POINTER, ptr);
    exp_pc = exp_pc + 16'h0002;
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(68));
    for (int i = 0; i < 8; i++) exp_ar[i] = 16'h0000;
    ptr = 3'h0;
    exp_pc = 16'h0000;
    repeat (12) @(posedge CLOCK);
    @(negedge CLOCK);
    RESETN = 1'b1;
    // each placement, single and repeated
    for (int f = 0; f < 5; f++) begin
      move(1'b0, 16'h0000, fl_tab[f]);
      move(1'b1, 16'h0002 + 16'(f), fl_tab[f]);
    end
    // random moves and calls, waits or not
    for (int i = 0; i < 40; i++) begin
      mode = 2'($urandom % 2);
      case ($urandom % 4)
        0: move(1'($urandom), 16'($urandom % 10), 3'h0);
        1: begin
          ACCUMULATOR = $urandom;
          run(bmce_pkg::OPC_ACC_CALL, 16'($urandom));
          chk(cyc, 4);
          chk(STACK_TOP, exp_pc + 16'h0001);
          exp_pc = ACCUMULATOR[15:0];
        end
        2: begin
          nxt = 1'($urandom % 2);
          nar = 3'($urandom);
          pma = 16'($urandom);
          run({bmce_pkg::OPC_IMM_CALL, 1'b1, bmce_pkg::ARU_INC, nxt, nar}, pma);
          chk(cyc, 4);
          chk(STACK_TOP, exp_pc + 16'h0002);
          exp_ar[ptr] = exp_ar[ptr] + 16'h0001;
          if (nxt) ptr = nar;
          chk(AUX_CURRENT, exp_ar[ptr]);
          exp_pc = pma;
        end
        default: begin
          COND_TRUE = 1'($urandom % 2);
          pma = 16'($urandom);
          run({bmce_pkg::OPC_COND_CALL, 10'h000}, pma);
          chk(cyc, COND_TRUE ? 4 : 2);
          exp_pc = COND_TRUE ? pma : exp_pc + 16'h0002;
        end
      endcase
      chk(PC, exp_pc);
    end
    // writes stalled: reads stop at buffer depth
    mode = 2'h2;
    fork
      move(1'b1, 16'h000B, 3'h0);
      begin
        repeat (20) @(negedge CLOCK);
        chk(rcnt, bmce_pkg::FIFO_DEPTH);
        mode = 2'h1;
      end
    join
    print_verdict();
  end

  // hang guard
  initial begin
    #(50 * 50000);
    error_cnt++;
    print_verdict();
  end
endmodule
